/* File: sps_switch.sv */
/*
 * Serial control core of an eight-channel low-side power switch.
 * Assumes the controller keeps the link timing; shiftClk is a clock
 * domain of its own and may stop between transfers.
 */
`timescale 1ns/1ns
module sps_switch #(
    parameter int BLANK_COUNT = sps_pkg::BLANK_CYCLES
) (
    // System.
    input wire logic ref_clk,
    input wire logic resetn,
    // Serial link.
    input wire logic shiftClk,
    input wire logic serialIn,
    input wire logic transfer_window_n,
    output logic serialOut,
    output logic serialOutEnN,
    // Drivers.
    input wire logic [sps_pkg::CHANNELS-1:0] outOfSat,
    output logic [sps_pkg::CHANNELS-1:0] driver_outputs
);
    import sps_pkg::*;

    // Window and sense, synchronised to the link clock when it runs.
    logic [CHANNELS-1:0] shift_q, shift_d;
    logic winLast_q, winLast_d;
    logic soBit_q, soBit_d;
    logic [CHANNELS-1:0] senseWord_q, senseWord_d;
    localparam int EN_CYC = ENABLE_MAX_CYCLES;

    // The shift register is loaded from the sensed outputs on the first
    // falling edge after the window opens, which stands for the window fall.
    // The sense word is frozen while the window is low, so it is steady here.
    always_comb begin
        shift_d = shift_q;
        winLast_d = transfer_window_n;
        if (!transfer_window_n) begin
            if (winLast_q) begin
                shift_d = senseWord_q;
            end else begin
                shift_d = {shift_q[CHANNELS-2:0], serialIn};
            end
        end
    end

    always_ff @(negedge shiftClk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= SHIFT_RESET;
        end else begin
            shift_q <= shift_d;
        end
    end

    // A closed window arms the capture at once, because the link clock
    // stands still between transfers and could not do it itself.
    always_ff @(negedge shiftClk or negedge resetn or posedge transfer_window_n) begin
        if (!resetn) begin
            winLast_q <= 1'b1;
        end else if (transfer_window_n) begin
            winLast_q <= 1'b1;
        end else begin
            winLast_q <= winLast_d;
        end
    end

    always_comb begin
        soBit_d = soBit_q;
        if (!transfer_window_n) begin
            soBit_d = shift_q[CHANNELS-1];
        end
    end

    always_ff @(posedge shiftClk or negedge resetn) begin
        if (!resetn) begin
            soBit_q <= 1'b0;
        end else begin
            soBit_q <= soBit_d;
        end
    end

    // Shift contents handed over by two-flop capture once the window rises;
    // the shift register is quiet then, so the word is stable.
    logic [2:0] winSync_q, winSync_d;
    logic [CHANNELS-1:0] word1_q, word1_d, word2_q, word2_d;
    logic [CHANNELS-1:0] satA_q, satA_d, satB_q, satB_d, satC_q, satC_d, satHigh;
    logic winFilt_q, winFilt_d;
    logic so1_q, so2_q, so_d;
    logic [CHANNELS-1:0] latch_q, latch_d;
    logic [31:0] blank_q, blank_d;
    logic serialOut_q, serialOut_d, soEnN_q, soEnN_d;
    logic [CHANNELS-1:0] drv_q, drv_d;
    logic winHigh, winRise;

    // A pin change counts once the second and third stages agree.
    assign winHigh = winFilt_q;
    assign winRise = winSync_q[1] & winSync_q[2] & ~winFilt_q;
    assign satHigh = satB_q & satC_q;

    always_comb begin
        winSync_d = {winSync_q[1:0], transfer_window_n};
        winFilt_d = winFilt_q;
        if (winSync_q[1] == winSync_q[2]) begin
            winFilt_d = winSync_q[2];
        end
        word1_d = shift_q;
        word2_d = word1_q;
        satA_d = outOfSat;
        satB_d = satA_q;
        satC_d = satB_q;
        // The sense word follows the outputs only while the window is closed.
        senseWord_d = senseWord_q;
        if (winFilt_q) begin
            senseWord_d = drv_q | satHigh;
        end
        so_d = soBit_q;
        latch_d = latch_q;
        blank_d = blank_q;
        if (winRise) begin
            latch_d = word2_q;
            blank_d = 32'(BLANK_COUNT);
        end else if (blank_q != 32'h0) begin
            blank_d = blank_q - 32'h1;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (!latch_q[i] && satHigh[i] && winHigh) begin
                    latch_d[i] = 1'b1;
                end
            end
        end
        soEnN_d = winFilt_d;
        serialOut_d = so2_q;
        drv_d = latch_d;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            winSync_q <= 3'h7;
            word1_q <= SHIFT_RESET;
            word2_q <= SHIFT_RESET;
            satA_q <= 8'h00;
            satB_q <= 8'h00;
            satC_q <= 8'h00;
            winFilt_q <= 1'b1;
            senseWord_q <= LATCH_RESET;
            so1_q <= 1'b0;
            so2_q <= 1'b0;
            latch_q <= LATCH_RESET;
            blank_q <= 32'h0;
            serialOut_q <= 1'b0;
            soEnN_q <= 1'b1;
            drv_q <= LATCH_RESET;
        end else begin
            winSync_q <= winSync_d;
            word1_q <= word1_d;
            word2_q <= word2_d;
            satA_q <= satA_d;
            satB_q <= satB_d;
            satC_q <= satC_d;
            winFilt_q <= winFilt_d;
            senseWord_q <= senseWord_d;
            so1_q <= so_d;
            so2_q <= so1_q;
            latch_q <= latch_d;
            blank_q <= blank_d;
            serialOut_q <= serialOut_d;
            soEnN_q <= soEnN_d;
            drv_q <= drv_d;
        end
    end

    assign serialOut = serialOut_q;
    assign serialOutEnN = soEnN_q;
    // Low on a driver means the output transistor is on.
    assign driver_outputs = drv_q;

    property p_enable;
        @(posedge ref_clk) disable iff (!resetn)
        $fell(transfer_window_n) |-> ##[1:EN_CYC] !serialOutEnN;
    endproperty
    a_enable: assert property (p_enable) else $error("output not enabled");

    property p_disable;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(transfer_window_n) |-> ##[1:EN_CYC] serialOutEnN;
    endproperty
    a_disable: assert property (p_disable) else $error("output not released");

    property p_valid;
        @(posedge ref_clk) disable iff (!resetn)
        ($rose(shiftClk) && !transfer_window_n) |-> ##3 serialOut == soBit_q;
    endproperty
    a_valid: assert property (p_valid) else $error("serial output late");

    property p_load;
        @(posedge ref_clk) disable iff (!resetn)
        winRise |=> driver_outputs == $past(word2_q);
    endproperty
    a_load: assert property (p_load) else $error("drivers not loaded");

    property p_blank;
        @(posedge ref_clk) disable iff (!resetn)
        (blank_q != 32'h0 && !winRise) |=> driver_outputs == $past(latch_q);
    endproperty
    a_blank: assert property (p_blank) else $error("unlatch during blanking");

    property p_timer;
        @(posedge ref_clk) disable iff (!resetn)
        winRise |=> blank_q == 32'(BLANK_COUNT);
    endproperty
    a_timer: assert property (p_timer) else $error("timer not started");

    property p_fault;
        @(posedge ref_clk) disable iff (!resetn)
        (blank_q == 32'h0 && !winRise && winHigh && !latch_q[0] && satHigh[0])
            |=> driver_outputs[0];
    endproperty
    a_fault: assert property (p_fault) else $error("fault not unlatched");

    property p_onlyfault;
        @(posedge ref_clk) disable iff (!resetn)
        (!winRise && !satB_q[1] && !latch_q[1]) |=> !driver_outputs[1];
    endproperty
    a_onlyfault: assert property (p_onlyfault) else $error("spurious off");

    property p_shift;
        @(negedge shiftClk) disable iff (!resetn)
        (!transfer_window_n && !winLast_q) |=> shift_q[0] == $past(serialIn);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted");

    property p_idle;
        @(negedge shiftClk) disable iff (!resetn)
        transfer_window_n |=> $stable(shift_q);
    endproperty
    a_idle: assert property (p_idle) else $error("clock not ignored");
endmodule

/* File: sps_pkg.sv */
/*
 * Constants shared by the serial power switch interface.
 * Assumes a 100 MHz system clock on ref_clk.
 */
package sps_pkg;
    localparam int REF_CLK_MHZ = 100;
    localparam int CHANNELS = 8;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam int ENABLE_MAX_NS = 1000;
    localparam int VALID_MAX_NS = 550;
    localparam int SWITCH_MAX_US = 10;
    localparam int BLANK_US = 100;
    localparam int BLANK_CYCLES = BLANK_US * REF_CLK_MHZ;
    localparam int ENABLE_MAX_CYCLES = ENABLE_MAX_NS * REF_CLK_MHZ / 1000;
    localparam int VALID_MAX_CYCLES = VALID_MAX_NS * REF_CLK_MHZ / 1000;
    localparam int SWITCH_MAX_CYCLES = SWITCH_MAX_US * REF_CLK_MHZ;
    localparam int UNLATCH_MIN_US = 75;
    localparam int UNLATCH_MAX_US = 450;
endpackage

/* File: sps_host_model.sv */
/* Controller model for the serial link of the power switch.
   Assumes the switch takes input on falling and drives output after rising edges. */
`timescale 1ns/1ns
module sps_host_model #(
    parameter int PHASE_NS = 703
) (
    // Link.
    output logic shiftClk,
    output logic serialIn,
    output logic transfer_window_n,
    input wire logic serialOut,
    input wire logic serialOutEnN
);
    initial begin
        shiftClk = 1'b0;
        serialIn = 1'b0;
        transfer_window_n = 1'b1;
    end
    // One dummy capture clock, then eight data clocks with driver 7 first.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic enSeen);
        #3;
        transfer_window_n = 1'b0;
        #1000;
        enSeen = serialOutEnN;
        for (int i = 0; i < 9; i++) begin
            #PHASE_NS;
            shiftClk = 1'b1;
            #200;
            if (i > 0) serialIn = tx[8-i];
            #(PHASE_NS - 200);
            if (i > 0) rx[8-i] = serialOutEnN ? ~serialOut : serialOut;
            shiftClk = 1'b0;
        end
        #1000;
        transfer_window_n = 1'b1;
        serialIn = ~serialIn;
    endtask
    // Clocks outside a frame, which the switch must ignore.
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #PHASE_NS shiftClk = 1'b1;
            #PHASE_NS shiftClk = 1'b0;
            serialIn = ~serialIn;
        end
    endtask
endmodule

/* File: tb.sv */
/* Self-checking bench of the power switch serial core.
   Assumes the controller model in its own file drives the link. */
`timescale 1ns/1ns
module tb;
    import sps_pkg::*;
    localparam int BLANK = 50;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] outOfSat = 8'h00;
    logic shiftClk, serialIn, windowN, serialOut, serialOutEnN;
    logic [7:0] drv;
    int err_total = 0;
    int checks = 0;
    always #5 ref_clk = ~ref_clk;
    sps_switch #(.BLANK_COUNT(BLANK)) u_dut(.ref_clk(ref_clk), .resetn(resetn),
        .shiftClk(shiftClk), .serialIn(serialIn), .transfer_window_n(windowN),
        .serialOut(serialOut), .serialOutEnN(serialOutEnN), .outOfSat(outOfSat),
        .driver_outputs(drv));
    sps_host_model u_host(.shiftClk(shiftClk), .serialIn(serialIn),
        .transfer_window_n(windowN), .serialOut(serialOut), .serialOutEnN(serialOutEnN));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] tx, input logic [7:0] expRx);
        logic [7:0] rx;
        logic en;
        u_host.xfer(tx, rx, en);
        chk("enable", 8'h00, {7'h00, en});
        chk("readback", expRx, rx);
        repeat (6) @(posedge ref_clk);
        chk("drivers", tx, drv);
        chk("release", 8'h01, {7'h00, serialOutEnN});
    endtask
    task automatic t_reset();
        chk("reset drivers", 8'hFF, drv);
        chk("reset release", 8'h01, {7'h00, serialOutEnN});
    endtask
    task automatic t_write();
        send(8'hA5, 8'hFF);
        send(8'h3C, 8'hA5);
    endtask
    task automatic t_idle();
        u_host.idle_clocks(4);
        repeat (4) @(posedge ref_clk);
        chk("idle drivers", 8'h3C, drv);
    endtask
    task automatic t_fault();
        send(8'hC3, 8'h3C);
        outOfSat <= 8'hFF;
        repeat (34) @(posedge ref_clk);
        chk("blanked", 8'hC3, drv);
        repeat (20) @(posedge ref_clk);
        chk("unlatched", 8'hFF, drv);
        outOfSat <= 8'h00;
    endtask
    initial begin
        repeat (120) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_write();
        t_idle();
        t_fault();
        tally_and_finish();
    end
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule
